// ==== logic/sae_pkg.sv ====
// constants, register layout and state types of the serial audio error-control block
//
// Notes on behaviour
// - rx_sign_extend set returns each receive word sign extended to 32 bits.
// - frame errors raise an error event only while frame_error_event_enable is set.
// - receive overflow raises an error event only while overflow_event_enable is set.
// - transmit underrun raises an error event only while underrun_event_enable is set.
// - overflow always keeps the queued word; tolerate_overflow keeps the engine running, otherwise overflow halts the engine.
// - tolerate_underrun sends zero words during underrun; otherwise underrun in framed operation halts the engine.
// - audio_codec_enable switches the engine from plain serial to audio codec framing.
// - mono_format in audio mode sends each word in both left and right slots.
// - audio_framing_select 00 I2S, 01 left, 10 right justified, 11 PCM/DSP.
// - audio enable, mono and framing fields take writes only while module disabled.
// - mono and framing fields are ignored unless audio_codec_enable is set.
// - unassigned bits of serial_control_two read zero and ignore writes.
// - rx_overflow_flag sets on discarded word; cleared by enable toggle or writing zero.
// - tx_underrun_flag only in framed operation; cleared by enable toggle or writing zero.
`default_nettype none

package sae_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] SAE_OFS_CTRL2 = 8'h00;
    localparam logic [7:0] SAE_OFS_CTRL = 8'h04;
    localparam logic [7:0] SAE_OFS_FLAGS = 8'h08;
    localparam logic [7:0] SAE_OFS_RXDATA = 8'h0C;
    localparam logic [7:0] SAE_OFS_TXDATA = 8'h10;
    localparam logic [7:0] SAE_OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] SAE_OFS_IRQ_MASK = 8'h18;

    // writable bits of serial_control_two, split by write condition
    localparam logic [31:0] SAE_CTRL2_FREE_MASK = 32'h0000_9F00;
    localparam logic [31:0] SAE_CTRL2_LOCKED_MASK = 32'h0000_008B;
    localparam logic [31:0] SAE_CTRL2_RST = 32'h0000_0000;

    // control register fields
    localparam int SAE_CTRL_ENABLE_BIT = 0;
    localparam int SAE_CTRL_FRAMED_BIT = 1;

    // flag register fields
    localparam int SAE_FLAG_OVF_BIT = 0;
    localparam int SAE_FLAG_UDR_BIT = 1;
    localparam int SAE_FLAG_FERR_BIT = 2;

    // interrupt status / mask fields
    localparam int SAE_IRQ_RX_BIT = 0;
    localparam int SAE_IRQ_TX_BIT = 1;
    localparam int SAE_IRQ_ERR_BIT = 2;
    localparam int SAE_IRQ_W = 3;

    // link word
    localparam int SAE_WORD_W = 16;
    localparam logic [3:0] SAE_LAST_BIT = 4'hF;

    // audio framing codes
    localparam logic [1:0] SAE_FRAME_I2S = 2'h0;
    localparam logic [1:0] SAE_FRAME_LEFT = 2'h1;
    localparam logic [1:0] SAE_FRAME_RIGHT = 2'h2;
    localparam logic [1:0] SAE_FRAME_PCM = 2'h3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] zero_hi;
        logic rx_sign_extend;
        logic [1:0] zero_a;
        logic frame_error_event_enable;
        logic overflow_event_enable;
        logic underrun_event_enable;
        logic tolerate_overflow;
        logic tolerate_underrun;
        logic audio_codec_enable;
        logic [2:0] zero_b;
        logic mono_format;
        logic zero_c;
        logic [1:0] audio_framing_select;
    } sae_ctrl2_t;

    typedef enum logic [1:0] {SAE_IDLE, SAE_RUN, SAE_HALT} sae_eng_t;

    typedef struct packed {
        sae_ctrl2_t ctrl2;
        logic mod_en;
        logic framed_mode_enable;
        logic rx_overflow_flag;
        logic tx_underrun_flag;
        logic frame_error_flag;
        logic [15:0] rx_hold;
        logic rx_full;
        logic rd_rx;
        logic [15:0] tx_hold;
        logic tx_full;
        logic [15:0] tx_last;
        logic [15:0] rx_shift;
        logic [15:0] tx_shift;
        logic [3:0] bitcnt;
        logic loaded;
        logic skip;
        logic chan;
        sae_eng_t eng;
        logic [2:0] sck_s;
        logic [1:0] sdi_s;
        logic [2:0] fs_s;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic err_evt;
        logic irq;
        logic sdo;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sae_state_t;

endpackage

`default_nettype wire

// ==== logic/sae_top.sv ====
// serial audio error-control slice: registers, error gating and a compact link engine
`default_nettype none

module sae_top
    import sae_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial link, inputs asynchronous to pclk, sdo registered on pclk
    input wire logic sck,
    input wire logic sdi,
    input wire logic fs,
    output logic sdo,
    // events
    output logic error_event,
    output logic irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rx_word(input logic [15:0] w, input logic ext);
        rx_word = ext ? {{16{w[15]}}, w} : {16'h0000, w};
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == SAE_OFS_CTRL2) || (a == SAE_OFS_CTRL) || (a == SAE_OFS_FLAGS) ||
                  (a == SAE_OFS_RXDATA) || (a == SAE_OFS_TXDATA) ||
                  (a == SAE_OFS_IRQ_STAT) || (a == SAE_OFS_IRQ_MASK);
    endfunction

    sae_state_t s_ff;
    sae_state_t nxt_s;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic setup;
        logic acc;
        logic sck_rise;
        logic sck_fall;
        logic fs_evt;
        logic audio;
        logic framed;
        logic [1:0] fmode;
        logic [31:0] rd;
        logic [31:0] c2;
        logic [15:0] word;
        logic popped;
        logic stored;
        logic err_now;
        setup = psel && !penable;
        acc = psel && penable && s_ff.pready;
        sck_rise = s_ff.sck_s[1] && !s_ff.sck_s[2];
        sck_fall = !s_ff.sck_s[1] && s_ff.sck_s[2];
        audio = s_ff.ctrl2.audio_codec_enable;
        fmode = audio ? s_ff.ctrl2.audio_framing_select : SAE_FRAME_PCM;
        framed = audio || s_ff.framed_mode_enable;
        // lr-clock framings start a slot on either edge, pulse framings on the rise
        fs_evt = framed && ((s_ff.fs_s[1] && !s_ff.fs_s[2]) ||
                 (fmode != SAE_FRAME_PCM && !s_ff.fs_s[1] && s_ff.fs_s[2]));
        rd = 32'h0000_0000;
        c2 = 32'h0000_0000;
        word = 16'h0000;
        popped = 1'b0;
        stored = 1'b0;
        nxt_s = s_ff;

        // synchronisers: two stages on sdi; sck and fs add a third stage, and edges are detected on stages 1 and 2
        nxt_s.sck_s = {s_ff.sck_s[1:0], sck};
        nxt_s.sdi_s = {s_ff.sdi_s[0], sdi};
        nxt_s.fs_s = {s_ff.fs_s[1:0], fs};

        // ------------------------------------------------------------
        // apb: zero wait states, answer in the first access cycle
        // ------------------------------------------------------------
        nxt_s.pready = 1'b0;
        nxt_s.pslverr = 1'b0;
        if (setup)
        begin
            unique case (paddr)
                SAE_OFS_CTRL2: rd = s_ff.ctrl2;
                SAE_OFS_CTRL: rd = {30'h0000_0000, s_ff.framed_mode_enable, s_ff.mod_en};
                SAE_OFS_FLAGS: rd = {29'h0000_0000, s_ff.frame_error_flag,
                                     s_ff.tx_underrun_flag, s_ff.rx_overflow_flag};
                SAE_OFS_RXDATA: rd = rx_word(s_ff.rx_hold, s_ff.ctrl2.rx_sign_extend);
                SAE_OFS_IRQ_STAT: rd = {29'h0000_0000, s_ff.irq_stat};
                SAE_OFS_IRQ_MASK: rd = {29'h0000_0000, s_ff.irq_mask};
                default: rd = 32'h0000_0000;
            endcase
            nxt_s.pready = 1'b1;
            nxt_s.pslverr = !addr_ok(paddr);
            nxt_s.prdata = rd;
            nxt_s.rd_rx = !pwrite && paddr == SAE_OFS_RXDATA && s_ff.rx_full;
        end

        // clears first, so a hardware set later in this process wins
        if (acc && !pwrite)
        begin
            if (paddr == SAE_OFS_IRQ_STAT)
            begin
                // only the bits that were actually reported are cleared
                nxt_s.irq_stat = s_ff.irq_stat & ~s_ff.prdata[SAE_IRQ_W-1:0];
            end
            if (paddr == SAE_OFS_RXDATA && s_ff.rd_rx)
            begin
                nxt_s.rx_full = 1'b0;
            end
        end
        if (acc && pwrite)
        begin
            unique case (paddr)
                SAE_OFS_CTRL2:
                begin
                    c2 = s_ff.ctrl2;
                    c2 = (c2 & ~SAE_CTRL2_FREE_MASK) | (pwdata & SAE_CTRL2_FREE_MASK);
                    if (!s_ff.mod_en)
                    begin
                        c2 = (c2 & ~SAE_CTRL2_LOCKED_MASK) | (pwdata & SAE_CTRL2_LOCKED_MASK);
                    end
                    nxt_s.ctrl2 = c2;
                end
                SAE_OFS_CTRL:
                begin
                    nxt_s.mod_en = pwdata[SAE_CTRL_ENABLE_BIT];
                    nxt_s.framed_mode_enable = pwdata[SAE_CTRL_FRAMED_BIT];
                end
                SAE_OFS_FLAGS:
                begin
                    // writing zero clears, writing one leaves the flag alone
                    if (!pwdata[SAE_FLAG_OVF_BIT])
                    begin
                        nxt_s.rx_overflow_flag = 1'b0;
                    end
                    if (!pwdata[SAE_FLAG_UDR_BIT])
                    begin
                        nxt_s.tx_underrun_flag = 1'b0;
                    end
                    if (!pwdata[SAE_FLAG_FERR_BIT])
                    begin
                        nxt_s.frame_error_flag = 1'b0;
                    end
                end
                SAE_OFS_TXDATA:
                begin
                    // a write into a full holding register overwrites it
                    nxt_s.tx_hold = pwdata[SAE_WORD_W-1:0];
                    nxt_s.tx_full = 1'b1;
                end
                SAE_OFS_IRQ_MASK: nxt_s.irq_mask = pwdata[SAE_IRQ_W-1:0];
                default: nxt_s.irq_mask = s_ff.irq_mask;
            endcase
        end

        // ------------------------------------------------------------
        // link engine
        // ------------------------------------------------------------
        if (!s_ff.mod_en)
        begin
            // disabled acts as soft reset: flags, queues and engine
            nxt_s.eng = SAE_IDLE;
            nxt_s.rx_overflow_flag = 1'b0;
            nxt_s.tx_underrun_flag = 1'b0;
            nxt_s.frame_error_flag = 1'b0;
            nxt_s.rx_full = 1'b0;
            nxt_s.tx_full = 1'b0;
            nxt_s.bitcnt = 4'h0;
            nxt_s.loaded = 1'b0;
            nxt_s.skip = 1'b0;
            nxt_s.chan = 1'b0;
            nxt_s.tx_shift = 16'h0000;
        end
        else if (s_ff.eng == SAE_IDLE)
        begin
            nxt_s.eng = SAE_RUN;
        end
        else if (s_ff.eng == SAE_RUN)
        begin
            if (fs_evt)
            begin
                if (s_ff.bitcnt != 4'h0)
                begin
                    nxt_s.frame_error_flag = 1'b1;
                end
                nxt_s.bitcnt = 4'h0;
                nxt_s.loaded = 1'b0;
                // i2s data starts one bit clock after the word-select edge
                nxt_s.skip = (fmode == SAE_FRAME_I2S);
                if (fmode == SAE_FRAME_PCM)
                begin
                    nxt_s.chan = audio ? !s_ff.chan : 1'b0;
                end
                else if (fmode == SAE_FRAME_I2S)
                begin
                    nxt_s.chan = s_ff.fs_s[1];
                end
                else
                begin
                    nxt_s.chan = !s_ff.fs_s[1];
                end
            end
            if (sck_rise)
            begin
                if (s_ff.skip)
                begin
                    nxt_s.skip = 1'b0;
                end
                else
                begin
                    nxt_s.rx_shift = {s_ff.rx_shift[14:0], s_ff.sdi_s[1]};
                    nxt_s.bitcnt = 4'(s_ff.bitcnt + 4'h1);
                    if (s_ff.bitcnt == SAE_LAST_BIT)
                    begin
                        nxt_s.bitcnt = 4'h0;
                        nxt_s.loaded = 1'b0;
                        if (!framed)
                        begin
                            nxt_s.chan = 1'b0;
                        end
                        else if (fmode == SAE_FRAME_PCM && audio)
                        begin
                            nxt_s.chan = !s_ff.chan;
                        end
                        if (s_ff.rx_full)
                        begin
                            // new word is dropped, queued word survives
                            nxt_s.rx_overflow_flag = 1'b1;
                            if (!s_ff.ctrl2.tolerate_overflow)
                            begin
                                nxt_s.eng = SAE_HALT;
                            end
                        end
                        else
                        begin
                            nxt_s.rx_hold = {s_ff.rx_shift[14:0], s_ff.sdi_s[1]};
                            nxt_s.rx_full = 1'b1;
                            stored = 1'b1;
                        end
                    end
                end
            end
            if (sck_fall && nxt_s.eng == SAE_RUN)
            begin
                if (!nxt_s.loaded)
                begin
                    nxt_s.loaded = 1'b1;
                    if (audio && s_ff.ctrl2.mono_format && nxt_s.chan)
                    begin
                        word = s_ff.tx_last;
                    end
                    else if (s_ff.tx_full)
                    begin
                        word = s_ff.tx_hold;
                        popped = 1'b1;
                    end
                    else
                    begin
                        // underrun: only framed operation reports it
                        word = 16'h0000;
                        if (framed)
                        begin
                            nxt_s.tx_underrun_flag = 1'b1;
                            if (!s_ff.ctrl2.tolerate_underrun)
                            begin
                                nxt_s.eng = SAE_HALT;
                            end
                        end
                    end
                    nxt_s.tx_last = word;
                    nxt_s.tx_shift = word;
                end
                else if (s_ff.bitcnt != 4'h0)
                begin
                    nxt_s.tx_shift = {s_ff.tx_shift[14:0], 1'b0};
                end
            end
            if (popped && !(acc && pwrite && paddr == SAE_OFS_TXDATA))
            begin
                nxt_s.tx_full = 1'b0;
            end
        end
        // a halted engine waits for the module to be disabled

        nxt_s.sdo = (nxt_s.eng == SAE_RUN) ? nxt_s.tx_shift[15] : 1'b0;

        // ------------------------------------------------------------
        // error event and interrupt
        // ------------------------------------------------------------
        err_now = (nxt_s.frame_error_flag && nxt_s.ctrl2.frame_error_event_enable) ||
                  (nxt_s.rx_overflow_flag && nxt_s.ctrl2.overflow_event_enable) ||
                  (nxt_s.tx_underrun_flag && nxt_s.ctrl2.underrun_event_enable);
        nxt_s.err_evt = err_now;
        if (stored)
        begin
            nxt_s.irq_stat[SAE_IRQ_RX_BIT] = 1'b1;
        end
        if (popped)
        begin
            nxt_s.irq_stat[SAE_IRQ_TX_BIT] = 1'b1;
        end
        if (err_now && !s_ff.err_evt)
        begin
            nxt_s.irq_stat[SAE_IRQ_ERR_BIT] = 1'b1;
        end
        nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign sdo = s_ff.sdo;
    assign error_event = s_ff.err_evt;
    assign irq = s_ff.irq;

endmodule

`default_nettype wire

// ==== tb/sae_sva.sv ====
// port-level assertions for the serial audio error-control slice
`default_nettype none

module sae_sva
    import sae_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // link and events
    input wire logic sdo,
    input wire logic error_event,
    input wire logic irq
);
    // ----------------
    // shadow of software writes
    // ----------------
    logic [31:0] sh_ff;
    logic en_ff;
    logic [2:0] msk_ff;
    logic [3:0] age_ff;
    logic done;
    logic wdone;
    logic mapped;
    logic [31:0] wmask;

    assign done = psel && penable && pready;
    assign wdone = done && pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= SAE_OFS_IRQ_MASK);
    // locked fields only move while the module is off
    assign wmask = SAE_CTRL2_FREE_MASK | (en_ff ? 32'h0 : SAE_CTRL2_LOCKED_MASK);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_ff <= SAE_CTRL2_RST;
            en_ff <= 1'b0;
            msk_ff <= 3'h0;
            age_ff <= 4'hF;
        end
        else
        begin
            if (wdone && paddr == SAE_OFS_CTRL2)
                sh_ff <= (sh_ff & ~wmask) | (pwdata & wmask);
            if (wdone && paddr == SAE_OFS_CTRL)
                en_ff <= pwdata[SAE_CTRL_ENABLE_BIT];
            if (wdone && paddr == SAE_OFS_IRQ_MASK)
                msk_ff <= pwdata[2:0];
            age_ff <= wdone ? 4'h0 : ((age_ff == 4'hF) ? 4'hF : age_ff + 4'h1);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------
    // properties
    // ----------------
    property p_rsvd_zero;
        done && !pwrite && paddr == SAE_OFS_CTRL2
            |-> (prdata & ~(SAE_CTRL2_FREE_MASK | SAE_CTRL2_LOCKED_MASK)) == 32'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("ctrl2 spare bits set");

    property p_readback;
        done && !pwrite && paddr == SAE_OFS_CTRL2 |-> prdata == sh_ff;
    endproperty
    a_readback: assert property (p_readback) else $error("ctrl2 readback differs");

    property p_err_off;
        (sh_ff[12:10] == 3'h0) [*2] |-> !error_event;
    endproperty
    a_err_off: assert property (p_err_off) else $error("event with enables off");

    property p_err_rise;
        $rose(error_event) |-> sh_ff[12:10] != 3'h0;
    endproperty
    a_err_rise: assert property (p_err_rise) else $error("event rose ungated");

    property p_err_fall;
        $fell(error_event) |-> age_ff <= 4'h4;
    endproperty
    a_err_fall: assert property (p_err_fall) else $error("event fell unprompted");

    property p_irq_off;
        (msk_ff == 3'h0) [*2] |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while fully masked");

    property p_ready_pulse;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready not one cycle");

    property p_slverr;
        done |-> pslverr == !mapped;
    endproperty
    a_slverr: assert property (p_slverr) else $error("slave error wrong");

    property p_sdo_off;
        (!en_ff) [*2] |-> !sdo;
    endproperty
    a_sdo_off: assert property (p_sdo_off) else $error("sdo active while off");

    c_err: cover property ($rose(error_event));
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (done && pslverr);
endmodule

`default_nettype wire

// ==== tb/sae_link_model.sv ====
// behavioural far-side link master: bit clock, frame sync and serial data
`default_nettype none

module sae_link_model
(
    // link pins
    output logic sck,
    output logic sdi,
    output logic fs,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sck = 1'b1;
        sdi = 1'b1;
        fs = 1'b0;
    end

    // msb first, nb bits; the clock stands high between words
    task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] got);
        got = 16'h0;
        // a sync edge opens each word
        fs = ~fs;
        #32;
        for (int i = 15; i > 15 - nb; i--)
        begin
            sck = 1'b0;
            sdi = w[i];
            #32;
            sck = 1'b1;
            // sample late: sdo moves after the detected fall
            #28;
            got = {got[14:0], sdo};
            #4;
        end
        // released line shows the inverse
        sdi = ~sdi;
        #96;
    endtask
endmodule

`default_nettype wire

// ==== tb/spi_audio_error_control_test.sv ====
// self-checking bench for the serial audio error-control slice
`default_nettype none

module spi_audio_error_control_test
    import sae_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] A_C2 = SAE_OFS_CTRL2;
    localparam logic [7:0] A_CT = SAE_OFS_CTRL;
    localparam logic [7:0] A_FL = SAE_OFS_FLAGS;
    localparam logic [7:0] A_RX = SAE_OFS_RXDATA;
    localparam logic [7:0] A_TX = SAE_OFS_TXDATA;
    localparam logic [7:0] A_IS = SAE_OFS_IRQ_STAT;
    localparam logic [7:0] A_IM = SAE_OFS_IRQ_MASK;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sck, sdi, fs, sdo, error_event, irq, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] lrx;
    int n_fail, check_count;

    sae_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sck, .sdi, .fs, .sdo, .error_event, .irq);
    sae_link_model u_link (.sck, .sdi, .fs, .sdo);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        last_err = pslverr;
        if (pready !== 1'b1)
        begin
            n_fail++;
            finish_test();
        end
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic lx(input logic [15:0] w);
        u_link.xfer(w, 16, lrx);
        apb(1'b0, A_RX, 32'h0);
    endtask

    // outputs are registered
    task automatic pins(input logic [1:0] e);
        repeat (2) @(negedge pclk);
        chk({30'h0, irq, error_event}, {30'h0, e});
    endtask

    initial
    begin
        n_fail = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // ----------------
        // registers
        // ----------------
        rdc(A_C2, SAE_CTRL2_RST);
        wr(A_C2, 32'hFFFF_FFFF);
        rdc(A_C2, 32'h0000_9F8B);
        wr(A_CT, 32'h0000_0001);
        wr(A_C2, 32'h0000_0000);
        rdc(A_C2, 32'h0000_008B);
        wr(A_CT, 32'h0000_0000);
        for (int m = 0; m < 4; m++)
        begin
            wr(A_C2, 32'h0000_0088 | 32'(m));
            rdc(A_C2, 32'h0000_0088 | 32'(m));
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        $display("test registers done");
        // ----------------
        // plain words, sign extension, interrupt
        // ----------------
        wr(A_C2, 32'h0000_000B);
        wr(A_IM, 32'h0000_0001);
        wr(A_CT, 32'h0000_0001);
        wr(A_TX, 32'h0000_A5C3);
        u_link.xfer(16'h8421, 16, lrx);
        chk({16'h0, lrx}, 32'h0000_A5C3);
        pins(2'b10);
        rdc(A_RX, 32'h0000_8421);
        apb(1'b0, A_IS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        pins(2'b00);
        wr(A_IM, 32'h0000_0000);
        wr(A_C2, 32'h0000_8000);
        u_link.xfer(16'h8001, 16, lrx);
        pins(2'b00);
        rdc(A_RX, 32'hFFFF_8001);
        u_link.xfer(16'h1234, 16, lrx);
        rdc(A_RX, 32'h0000_1234);
        $display("test plain done");
        // ----------------
        // receive overflow
        // ----------------
        wr(A_C2, 32'h0000_0A00);
        u_link.xfer(16'h1111, 16, lrx);
        u_link.xfer(16'h2222, 16, lrx);
        rdc(A_FL, 32'h1);
        pins(2'b01);
        rdc(A_RX, 32'h0000_1111);
        lx(16'h3333);
        chk(rd, 32'h0000_3333);
        wr(A_FL, 32'h0);
        pins(2'b00);
        rdc(A_FL, 32'h0);
        wr(A_C2, 32'h0000_0200);
        u_link.xfer(16'h4444, 16, lrx);
        u_link.xfer(16'h5555, 16, lrx);
        rdc(A_FL, 32'h1);
        pins(2'b00);
        wr(A_C2, 32'h0000_0800);
        wr(A_FL, 32'h0);
        rdc(A_RX, 32'h0000_4444);
        u_link.xfer(16'h6666, 16, lrx);
        u_link.xfer(16'h7777, 16, lrx);
        pins(2'b01);
        rdc(A_RX, 32'h0000_6666);
        wr(A_FL, 32'h0);
        u_link.xfer(16'h8888, 16, lrx);
        u_link.xfer(16'h9999, 16, lrx);
        rdc(A_FL, 32'h0);
        wr(A_CT, 32'h0);
        wr(A_CT, 32'h1);
        lx(16'hABCD);
        chk(rd, 32'h0000_ABCD);
        $display("test overflow done");
        // ----------------
        // framed underrun
        // ----------------
        wr(A_CT, 32'h0);
        wr(A_C2, 32'h0000_0500);
        wr(A_CT, 32'h3);
        lx(16'h0F0F);
        chk({16'h0, lrx}, 32'h0);
        rdc(A_FL, 32'h2);
        pins(2'b01);
        wr(A_TX, 32'h0000_5A5A);
        lx(16'h0F0F);
        chk({16'h0, lrx}, 32'h0000_5A5A);
        wr(A_CT, 32'h0);
        wr(A_CT, 32'h3);
        rdc(A_FL, 32'h0);
        wr(A_C2, 32'h0);
        lx(16'h0F0F);
        rdc(A_FL, 32'h2);
        pins(2'b00);
        wr(A_TX, 32'h0000_7E7E);
        lx(16'h0F0F);
        chk({16'h0, lrx}, 32'h0);
        $display("test underrun done");
        // ----------------
        // frame error
        // ----------------
        wr(A_CT, 32'h0);
        wr(A_C2, 32'h0000_1100);
        wr(A_CT, 32'h3);
        wr(A_TX, 32'h1);
        u_link.xfer(16'h00FF, 8, lrx);
        wr(A_TX, 32'h2);
        lx(16'h1234);
        rdc(A_FL, 32'h4);
        pins(2'b01);
        wr(A_C2, 32'h0000_0100);
        pins(2'b00);
        $display("test frame error done");
        finish_test();
    end
endmodule

bind sae_top sae_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sdo, .error_event, .irq);

`default_nettype wire
